// ---- scdc_defs.vh ----
// Constants for the system clock divide control block.
// Assumes one crystal-rate clock; included by its bare name.
`ifndef SCDC_DEFS_VH
`define SCDC_DEFS_VH

// Register indices on the plain register port
`define SCDC_ADDR_W 4
`define SCDC_DATA_W 8
`define SCDC_REG_PMR 4'h0
`define SCDC_REG_STAT 4'h1
`define SCDC_REG_TSEL 4'h2

// Power management register fields
`define SCDC_PMR_CD_HI 7
`define SCDC_PMR_CD_LO 6
`define SCDC_PMR_SWB 5
`define SCDC_PMR_MEN 4
`define SCDC_PMR_MFS 3

// Status register fields
`define SCDC_ST_CLOCK_READY_FLAG 0
`define SCDC_ST_RING 1
`define SCDC_ST_OSCOK 2
`define SCDC_ST_BUSY 3

// Timer select register fields: high bits 2:0, low bits 5:3
`define SCDC_TS_HI_LSB 0
`define SCDC_TS_LO_LSB 3

// Clock-divide field codes
`define SCDC_CD_MUL 2'h0
`define SCDC_CD_RSV 2'h1
`define SCDC_CD_DIV1 2'h2
`define SCDC_CD_SLOW 2'h3
`define SCDC_CD_RESET 2'h2

// Effective system clock source codes
`define SCDC_SRC_X4 2'h0
`define SCDC_SRC_X2 2'h1
`define SCDC_SRC_X1 2'h2
`define SCDC_SRC_SLOW 2'h3

// Dividers
`define SCDC_SLOW_DIV_W 10
`define SCDC_SLOW_LAST 10'h3FF
`define SCDC_T12_W 4
`define SCDC_T12_LAST 4'hB
`define SCDC_NUM_TIMERS 3
`define SCDC_STARTUP_CYCLES 65536
`define SCDC_STARTUP_W 17

`endif

// ---- scdc_startup_counter.v ----
// Startup counter shared by crystal warmup and multiplier startup.
// Assumes start is a one-cycle pulse; done holds until the next start.
`include "scdc_defs.vh"

module scdc_startup_counter #(
	parameter COUNT = `SCDC_STARTUP_CYCLES
) (
	// Clock, reset, enable
	input wire clk,
	input wire rst_b,
	input wire ce,
	// Control
	input wire start,
	// Status
	output reg busy_q,
	output reg done_q
);

	reg [`SCDC_STARTUP_W-1:0] cnt_q;
	wire [`SCDC_STARTUP_W-1:0] lastCnt;
	wire [31:0] lastCntFull;

	// Terminal count, cut to the counter width on purpose
	assign lastCntFull = COUNT - 1;
	assign lastCnt = lastCntFull[`SCDC_STARTUP_W-1:0];

	////////////////////////////////////////////////////////////////////
	// Count COUNT cycles after each start, then flag done
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= {`SCDC_STARTUP_W{1'b0}};
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			if (start) begin
				cnt_q <= {`SCDC_STARTUP_W{1'b0}};
				busy_q <= 1'b1;
				done_q <= 1'b0;
			end else if (busy_q) begin
				if (cnt_q == lastCnt) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

endmodule

// ---- scdc_clock_control.v ----
// System clock selection and divide control with multiplier interlocks.
// Assumes clk is the crystal clock and all inputs are synchronous to it.
//
// How it works
// - Multiplier runs at 2x or 4x by select bit, only while enabled.
// - A slow source equal to crystal clock divided by 1024 exists.
// - Reserved divide code 01 clocks like 10, undivided, but reads back as 01.
// - Every reset selects divide-by-1.
// - Divide field writes are accepted any time, apart from interlocks.
// - In slow mode with switchback on, external interrupt forces divide-by-1.
// - In slow mode a serial start bit switches back to divide-by-1.
// - Switchback acts only in slow mode; other modes stay unchanged.
// - Timer select 00 with fast ratios feeds that timer crystal over 12.
// - Multiplied clock is never used before the ready flag is set.
// - Factor select writes are ignored unless the multiplier is off.
// - Enable writes ignored unless divide-by-1 and ring oscillator idle.
// - Enable rising clears ready and starts the startup counter.
// - During startup ready stays low and divide code 00 is refused.
// - Every reset clears the multiplier enable.
// - One counter times 65,536 cycles for warmup and multiplier startup.
`include "scdc_defs.vh"

module scdc_clock_control #(
	parameter STARTUP_CYCLES = `SCDC_STARTUP_CYCLES
) (
	// Clock, reset, enable
	input wire clk,
	input wire rst_b,
	input wire ce,
	// Register port
	input wire [`SCDC_ADDR_W-1:0] regAddr,
	input wire [`SCDC_DATA_W-1:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [`SCDC_DATA_W-1:0] regRdData_q,
	// Events and status from the core
	input wire ringOscActive,
	input wire extIntDetected,
	input wire [1:0] startBitDetected,
	// Clock source control
	output reg [1:0] sysClkSrc_q,
	output reg multiplierRun_q,
	output reg multiplyFactor_q,
	output reg oscReady_q,
	output reg slowTick_q,
	output reg sysTick_q,
	// Timer input clocks
	output reg [`SCDC_NUM_TIMERS-1:0] timerTick_q
);

	////////////////////////////////////////////////////////////////////
	// Startup sequencer states
	localparam ST_WARMUP = 2'b00;
	localparam ST_IDLE = 2'b01;
	localparam ST_MULSTART = 2'b10;
	localparam ST_MULREADY = 2'b11;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [1:0] clkDivSel_q;
	reg [1:0] clkDivSel_d;
	reg switchbackEnable_q;
	reg multiplierEnable_q;
	reg multiplierEnable_d;
	reg multiplyFactorSel_q;
	reg multiplyFactorSel_d;
	reg [`SCDC_NUM_TIMERS-1:0] timerClkSelHi_q;
	reg [`SCDC_NUM_TIMERS-1:0] timerClkSelLo_q;
	reg [`SCDC_SLOW_DIV_W-1:0] slowCnt_q;
	reg [`SCDC_T12_W-1:0] t12Cnt_q;
	reg powerUp_q;
	reg [`SCDC_DATA_W-1:0] rdData_d;

	wire pmrWr;
	wire tselWr;
	wire divIsOne;
	wire divIsSlow;
	wire divIsFast;
	wire clockReadyFlag;
	wire cntStart;
	wire cntBusy;
	wire cntDone;
	wire switchback;
	wire slowEdge;
	wire t12Edge;
	wire [1:0] wrDivSel;

	////////////////////////////////////////////////////////////////////
	// Decode of the divide field
	assign divIsOne = (clkDivSel_q == `SCDC_CD_DIV1) ||
		(clkDivSel_q == `SCDC_CD_RSV);
	assign divIsSlow = (clkDivSel_q == `SCDC_CD_SLOW);
	assign divIsFast = !divIsSlow;
	assign clockReadyFlag = (state_q == ST_MULREADY);

	// Register write strobes
	assign pmrWr = regWr && (regAddr == `SCDC_REG_PMR);
	assign tselWr = regWr && (regAddr == `SCDC_REG_TSEL);
	assign wrDivSel = {regWrData[`SCDC_PMR_CD_HI],
		regWrData[`SCDC_PMR_CD_LO]};

	// Switchback events, only in slow mode
	assign switchback = divIsSlow && ((switchbackEnable_q &&
		extIntDetected) || (|startBitDetected));

	// Counter restarts on power-up and on each enable rising edge
	assign cntStart = powerUp_q ||
		(!multiplierEnable_q && multiplierEnable_d);

	assign slowEdge = (slowCnt_q == `SCDC_SLOW_LAST);
	assign t12Edge = (t12Cnt_q == `SCDC_T12_LAST);

	////////////////////////////////////////////////////////////////////
	// Shared startup counter
	scdc_startup_counter #(
		.COUNT(STARTUP_CYCLES)
	) uStartup (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.start(cntStart),
		.busy_q(cntBusy),
		.done_q(cntDone)
	);

	////////////////////////////////////////////////////////////////////
	// Multiplier enable and factor select with interlocks
	always @* begin
		multiplierEnable_d = multiplierEnable_q;
		multiplyFactorSel_d = multiplyFactorSel_q;
		if (pmrWr && divIsOne && !ringOscActive) begin
			multiplierEnable_d = regWrData[`SCDC_PMR_MEN];
		end
		if (pmrWr && !multiplierEnable_q) begin
			multiplyFactorSel_d = regWrData[`SCDC_PMR_MFS];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Divide field: writes, refusal of 00, switchback
	always @* begin
		clkDivSel_d = clkDivSel_q;
		if (pmrWr) begin
			if (wrDivSel != `SCDC_CD_MUL) begin
				clkDivSel_d = wrDivSel;
			end else if (clockReadyFlag && multiplierEnable_q) begin
				clkDivSel_d = wrDivSel;
			end
		end
		if (switchback) begin
			clkDivSel_d = `SCDC_CD_DIV1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Startup sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_WARMUP: begin
				if (cntDone) begin
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (multiplierEnable_d) begin
					state_d = ST_MULSTART;
				end
			end
			ST_MULSTART: begin
				if (!multiplierEnable_d) begin
					state_d = ST_IDLE;
				end else if (cntDone && !cntStart) begin
					state_d = ST_MULREADY;
				end
			end
			ST_MULREADY: begin
				if (!multiplierEnable_d) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Control registers
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_WARMUP;
			powerUp_q <= 1'b1;
			clkDivSel_q <= `SCDC_CD_RESET;
			switchbackEnable_q <= 1'b0;
			multiplierEnable_q <= 1'b0;
			multiplyFactorSel_q <= 1'b0;
			timerClkSelHi_q <= {`SCDC_NUM_TIMERS{1'b0}};
			timerClkSelLo_q <= {`SCDC_NUM_TIMERS{1'b0}};
		end else if (ce) begin
			powerUp_q <= 1'b0;
			state_q <= state_d;
			clkDivSel_q <= clkDivSel_d;
			multiplierEnable_q <= multiplierEnable_d;
			multiplyFactorSel_q <= multiplyFactorSel_d;
			if (pmrWr) begin
				switchbackEnable_q <= regWrData[`SCDC_PMR_SWB];
			end
			if (tselWr) begin
				timerClkSelHi_q <= regWrData[`SCDC_TS_HI_LSB +:
					`SCDC_NUM_TIMERS];
				timerClkSelLo_q <= regWrData[`SCDC_TS_LO_LSB +:
					`SCDC_NUM_TIMERS];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Free-running prescalers on the crystal clock
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slowCnt_q <= {`SCDC_SLOW_DIV_W{1'b0}};
			t12Cnt_q <= {`SCDC_T12_W{1'b0}};
		end else if (ce) begin
			slowCnt_q <= slowCnt_q + 1'b1;
			if (t12Edge) begin
				t12Cnt_q <= {`SCDC_T12_W{1'b0}};
			end else begin
				t12Cnt_q <= t12Cnt_q + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Clock source outputs
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sysClkSrc_q <= `SCDC_SRC_X1;
			multiplierRun_q <= 1'b0;
			multiplyFactor_q <= 1'b0;
			oscReady_q <= 1'b0;
			slowTick_q <= 1'b0;
			sysTick_q <= 1'b0;
		end else if (ce) begin
			multiplierRun_q <= multiplierEnable_q;
			multiplyFactor_q <= multiplyFactorSel_q;
			oscReady_q <= (state_q != ST_WARMUP);
			slowTick_q <= slowEdge;
			if (divIsSlow) begin
				sysClkSrc_q <= `SCDC_SRC_SLOW;
				sysTick_q <= slowEdge;
			end else if (clkDivSel_q == `SCDC_CD_MUL && clockReadyFlag) begin
				sysClkSrc_q <= multiplyFactorSel_q ? `SCDC_SRC_X4 :
					`SCDC_SRC_X2;
				sysTick_q <= 1'b1;
			end else begin
				sysClkSrc_q <= `SCDC_SRC_X1;
				sysTick_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Timer input clocks, one per timer
	genvar gi;
	generate
		for (gi = 0; gi < `SCDC_NUM_TIMERS; gi = gi + 1) begin : gTimer
			// Divide-by-12 for select 00 in the fast modes
			always @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					timerTick_q[gi] <= 1'b0;
				end else if (ce) begin
					if (!timerClkSelHi_q[gi] && !timerClkSelLo_q[gi] &&
						divIsFast) begin
						timerTick_q[gi] <= t12Edge;
					end else if (divIsSlow) begin
						timerTick_q[gi] <= slowEdge;
					end else begin
						timerTick_q[gi] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the read strobe
	always @* begin
		rdData_d = {`SCDC_DATA_W{1'b0}};
		if (regAddr == `SCDC_REG_PMR) begin
			rdData_d[`SCDC_PMR_CD_HI] = clkDivSel_q[1];
			rdData_d[`SCDC_PMR_CD_LO] = clkDivSel_q[0];
			rdData_d[`SCDC_PMR_SWB] = switchbackEnable_q;
			rdData_d[`SCDC_PMR_MEN] = multiplierEnable_q;
			rdData_d[`SCDC_PMR_MFS] = multiplyFactorSel_q;
		end else if (regAddr == `SCDC_REG_STAT) begin
			rdData_d[`SCDC_ST_CLOCK_READY_FLAG] = clockReadyFlag;
			rdData_d[`SCDC_ST_RING] = ringOscActive;
			rdData_d[`SCDC_ST_OSCOK] = (state_q != ST_WARMUP);
			rdData_d[`SCDC_ST_BUSY] = cntBusy;
		end else if (regAddr == `SCDC_REG_TSEL) begin
			rdData_d[`SCDC_TS_HI_LSB +: `SCDC_NUM_TIMERS] = timerClkSelHi_q;
			rdData_d[`SCDC_TS_LO_LSB +: `SCDC_NUM_TIMERS] = timerClkSelLo_q;
		end
	end

	// Read data register, zero when no read
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData_q <= {`SCDC_DATA_W{1'b0}};
		end else if (ce) begin
			regRdData_q <= regRd ? rdData_d : {`SCDC_DATA_W{1'b0}};
		end
	end

endmodule

// ---- scdc_clock_monitor.sv ----
// Checker for the clock divide control block, watching its ports only.
// Assumes one crystal clock and an async active-low reset.
`include "scdc_defs.vh"

module scdc_clock_monitor #(
	parameter STARTUP_CYCLES = `SCDC_STARTUP_CYCLES
) (
	// Clock and reset
	input logic clk,
	input logic rst_b,
	input logic ce,
	// Register port
	input logic [`SCDC_ADDR_W-1:0] regAddr,
	input logic [`SCDC_DATA_W-1:0] regWrData,
	input logic regWr,
	input logic regRd,
	input logic [`SCDC_DATA_W-1:0] regRdData_q,
	// Events
	input logic ringOscActive,
	input logic extIntDetected,
	input logic [1:0] startBitDetected,
	// Clock outputs
	input logic [1:0] sysClkSrc_q,
	input logic multiplierRun_q,
	input logic multiplyFactor_q,
	input logic oscReady_q,
	input logic slowTick_q,
	input logic sysTick_q,
	input logic [`SCDC_NUM_TIMERS-1:0] timerTick_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////////
	// Cycles since the last slow tick
	logic [9:0] gap_q;
	logic seen_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_q <= 10'h000;
			seen_q <= 1'b0;
		end else if (ce) begin
			gap_q <= slowTick_q ? 10'h000 : gap_q + 10'h001;
			seen_q <= seen_q | slowTick_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Steps of multiplier startup and slow-mode wakeup
	sequence sStartup;
		sysClkSrc_q[1] [*8];
	endsequence
	sequence sSlowStart;
		sysClkSrc_q == 2'h3 && startBitDetected != 2'h0 && ce;
	endsequence

	a_rd_idle: assert property (ce && !regRd |=> regRdData_q == 8'h00)
		else $error("read data not zero outside read slot");
	a_reset_state: assert property ($rose(rst_b) |->
		sysClkSrc_q == 2'h2 && !multiplierRun_q)
		else $error("reset state wrong");
	a_mult_src: assert property (sysClkSrc_q[1] == 1'b0 |->
		multiplierRun_q && multiplyFactor_q == !sysClkSrc_q[0])
		else $error("multiplied source without matching multiplier");
	a_factor_locked: assert property (multiplierRun_q |=>
		$stable(multiplyFactor_q))
		else $error("factor changed while multiplier on");
	a_run_gate: assert property ($rose(multiplierRun_q) |->
		$past(sysClkSrc_q) == 2'h2 && !$past(ringOscActive, 2))
		else $error("multiplier enabled outside undivided mode");
	a_startup_hold: assert property ($rose(multiplierRun_q) |->
		sStartup)
		else $error("multiplied source during startup");
	a_no_switch: assert property ($changed(sysClkSrc_q) |->
		$past(regWr, 2) || $past(sysClkSrc_q) == 2'h3)
		else $error("source changed without write outside slow mode");
	a_slow_wake: assert property (sSlowStart |=> ##1
		sysClkSrc_q == 2'h2)
		else $error("no switchback on start bit");
	a_slow_gap: assert property (slowTick_q && seen_q |->
		gap_q == 10'h3FF)
		else $error("slow tick period wrong");
	a_slow_sys: assert property (sysClkSrc_q == 2'h3 &&
		$past(sysClkSrc_q) == 2'h3 |-> sysTick_q == slowTick_q)
		else $error("system tick not slow in slow mode");
endmodule

bind scdc_clock_control scdc_clock_monitor #(
	.STARTUP_CYCLES(STARTUP_CYCLES)
) u_scdc_clock_monitor (.clk, .rst_b, .ce, .regAddr, .regWrData,
	.regWr, .regRd, .regRdData_q, .ringOscActive, .extIntDetected,
	.startBitDetected, .sysClkSrc_q, .multiplierRun_q, .multiplyFactor_q,
	.oscReady_q, .slowTick_q, .sysTick_q, .timerTick_q);

// ---- scdc_core_model.sv ----
// Model of the core side: ring oscillator mode and wakeup events.
// Assumes tasks are called right after a rising clock edge.
module scdc_core_model (
	// Clock
	input logic clk,
	// Events toward the clock control
	output logic ringOscActive,
	output logic extIntDetected,
	output logic [1:0] startBitDetected
);
	timeunit 1ns;
	timeprecision 100ps;

	// Quiet core at start
	initial begin
		ringOscActive = 1'b0;
		extIntDetected = 1'b0;
		startBitDetected = 2'h0;
	end

	// Ring oscillator mode level
	task automatic setRing(input logic v);
		ringOscActive <= v;
	endtask

	// One-cycle interrupt and start-bit pulse
	task automatic pulse(input logic i, input logic [1:0] s);
		extIntDetected <= i;
		startBitDetected <= s;
		@(posedge clk);
		extIntDetected <= 1'b0;
		startBitDetected <= 2'h0;
	endtask
endmodule

// ---- scdc_clock_control_bench.sv ----
// Self-checking bench for the clock divide control block.
// Assumes the monitor is bound to the design; short startup count.
`include "scdc_defs.vh"

module scdc_clock_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic [`SCDC_ADDR_W-1:0] regAddr = 4'h0;
	logic [`SCDC_DATA_W-1:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [`SCDC_DATA_W-1:0] regRdData_q;
	logic ringOscActive, extIntDetected, multiplierRun_q, multiplyFactor_q;
	logic oscReady_q, slowTick_q, sysTick_q;
	logic [1:0] startBitDetected, sysClkSrc_q;
	logic [`SCDC_NUM_TIMERS-1:0] timerTick_q;
	logic [7:0] cnt;
	int errCount = 0;
	int checkCount = 0;
	int cyc = 0;

	scdc_clock_control #(.STARTUP_CYCLES(16)) u_scdc_clock_control (.clk,
		.rst_b, .ce, .regAddr, .regWrData, .regWr, .regRd, .regRdData_q,
		.ringOscActive, .extIntDetected, .startBitDetected, .sysClkSrc_q,
		.multiplierRun_q, .multiplyFactor_q, .oscReady_q, .slowTick_q,
		.sysTick_q, .timerTick_q);
	scdc_core_model u_scdc_core_model (.clk, .ringOscActive,
		.extIntDetected, .startBitDetected);

	// Clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			errCount++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d, mismatches %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checkCount++;
		if (got !== exp) begin
			errCount++;
			$display("wrong value at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] d);
		regAddr <= `SCDC_REG_PMR;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] m, e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		chk(regRdData_q & m, e);
		@(posedge clk);
	endtask
	task automatic chkSrc(input logic [1:0] e);
		@(negedge clk);
		chk({6'h00, sysClkSrc_q}, {6'h00, e});
		@(posedge clk);
	endtask
	task automatic tally(input int n, input bit tmr, output logic [7:0] c);
		c = 8'h00;
		repeat (n) begin
			@(posedge clk);
			if ((tmr ? timerTick_q[0] : sysTick_q) === 1'b1) c++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		step(6);
		rst_b <= 1'b1;
		step(1);
		rd(`SCDC_REG_PMR, 8'hFF, 8'h80);
		rd(`SCDC_REG_TSEL, 8'hFF, 8'h00);
		rd(4'h5, 8'hFF, 8'h00);
		step(40);
		chk({7'h00, oscReady_q}, 8'h01);
		u_scdc_core_model.setRing(1'b1);
		wr(8'h90);
		rd(`SCDC_REG_PMR, 8'hFF, 8'h80);
		u_scdc_core_model.setRing(1'b0);
		wr(8'h90);
		rd(`SCDC_REG_STAT, 8'h01, 8'h00);
		wr(8'h10);
		rd(`SCDC_REG_PMR, 8'hFF, 8'h90);
		wr(8'h98);
		rd(`SCDC_REG_PMR, 8'hFF, 8'h90);
		step(30);
		rd(`SCDC_REG_STAT, 8'h01, 8'h01);
		wr(8'h10);
		chkSrc(2'h1);
		tally(120, 1'b1, cnt);
		chk(cnt, 8'd10);
		wr(8'h00);
		rd(`SCDC_REG_PMR, 8'hFF, 8'h10);
		wr(8'h90);
		wr(8'h80);
		wr(8'h88);
		rd(`SCDC_REG_PMR, 8'hFF, 8'h88);
		wr(8'h98);
		step(30);
		wr(8'h18);
		chkSrc(2'h0);
		wr(8'h98);
		wr(8'h80);
		wr(8'h40);
		chkSrc(2'h2);
		tally(120, 1'b1, cnt);
		chk(cnt, 8'd10);
		wr(8'hC0);
		chkSrc(2'h3);
		tally(2048, 1'b0, cnt);
		chk(cnt, 8'd2);
		u_scdc_core_model.pulse(1'b1, 2'h0);
		step(2);
		chkSrc(2'h3);
		wr(8'hE0);
		u_scdc_core_model.pulse(1'b1, 2'h0);
		step(2);
		chkSrc(2'h2);
		rd(`SCDC_REG_PMR, 8'hFF, 8'hA0);
		wr(8'hC0);
		u_scdc_core_model.pulse(1'b0, 2'h2);
		step(2);
		chkSrc(2'h2);
		wr(8'hA0);
		u_scdc_core_model.pulse(1'b1, 2'h3);
		step(2);
		rd(`SCDC_REG_PMR, 8'hFF, 8'hA0);
		wr(8'h90);
		rst_b <= 1'b0;
		step(2);
		rst_b <= 1'b1;
		step(1);
		rd(`SCDC_REG_PMR, 8'hFF, 8'h80);
		test_done();
	end
endmodule
